// ==== rtl/irq_timer_ctrl_instr_exec.sv ====
// Executor for interrupt gating, skip tests and control register moves.
//
// Operation
// - Interrupt-off clears the global gate flag.
// - Interrupt-on sets the global gate flag.
// - Select zero low: skip and clear set flag.
// - Select zero high: request-zero skip is null.
// - Select one low: skip and clear set flag.
// - Select one high: request-one skip is null.
// - Polarity zero set: skip when pin high.
// - Polarity zero clear: skip when pin low.
// - Polarity one set: skip when pin high.
// - Polarity one clear: skip when pin low.
// - Move first mask register to/from accumulator.
// - Move second mask register to/from accumulator.
// - Move first edge register to/from accumulator.
// - Move second edge register to/from accumulator.
// - Load auxiliary timer register, never read back.
// - Move timer registers one to five to/from accumulator.
`timescale 1ns/1ps

// Offsets, field positions and reset values come from the shared header.
`include "irq_timer_defines.svh"

module irq_timer_ctrl_instr_exec
	import irq_timer_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_b,
	input  wire instr_req_t  i_instr,
	input  wire logic [1:0]  i_ext_req_set,
	input  wire logic        i_ext_irq_pin_zero,
	input  wire logic        i_ext_irq_pin_one,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	output instr_rsp_t       o_rsp,
	output ctrl_regs_t       o_ctrl_regs,
	output logic             o_irq_global_gate_flag,
	output logic [1:0]       o_ext_req_flag,
	output logic             o_irq
);

	// Every flip-flop of the block except the reset synchroniser.
	typedef struct packed {
		ctrl_regs_t              regs;        // Held control registers.
		logic                    gate;        // Global interrupt gate.
		logic                    req_zero;    // External request flag zero.
		logic                    req_one;     // External request flag one.
		logic [1:0]              pin_s1;      // First pin sync stage.
		logic [1:0]              pin_s2;      // Second pin sync stage.
		logic                    skip_pend;   // Next instruction is dropped.
		instr_rsp_t              rsp;         // Answer to the core.
		logic [`EVT_WIDTH-1:0]   evt_status;  // Sticky events.
		logic [`EVT_WIDTH-1:0]   evt_mask;    // Interrupt enables.
		logic                    exec_en;     // Software run enable.
		logic [31:0]             prdata;      // Registered read data.
	} state_t;

	state_t      q;          // Current state.
	state_t      d;          // Next state.
	logic [1:0]  rst_sync_q; // Reset release synchroniser.
	logic        rst_n;      // Synchronised reset used by the design.

	// Reset is asserted at once but released only after two clean edges.
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Timer register select for the read path; the write path decodes its own index.
	function automatic logic [3:0] tmr_read(input ctrl_regs_t r,
		input logic [2:0] idx);
		case (idx)
			3'h0: tmr_read = r.timer_ctrl_reg_one;
			3'h1: tmr_read = r.timer_ctrl_reg_two;
			3'h2: tmr_read = r.timer_ctrl_reg_three;
			3'h3: tmr_read = r.timer_ctrl_reg_four;
			3'h4: tmr_read = r.timer_ctrl_reg_five;
			default: tmr_read = `RST_NIBBLE;
		endcase
	endfunction

	// APB phase qualifiers; the slave answers with no wait state.
	logic apb_acc;   // Access phase of any transfer.
	logic apb_wr;    // Write takes effect this edge.
	logic apb_rd;    // Read data is taken this edge.
	logic addr_ok;   // Address hits a mapped register.
	assign apb_acc = i_psel & i_penable;
	assign apb_wr  = apb_acc & i_pwrite;
	assign apb_rd  = apb_acc & ~i_pwrite;
	assign addr_ok = (i_paddr == `OFS_EVT_STATUS) ||
		(i_paddr == `OFS_EVT_MASK) || (i_paddr == `OFS_CORE_STATE) ||
		(i_paddr == `OFS_EXEC_CTRL);

	// Instruction taken this cycle while execution is enabled, unless it is the one a skip drops.
	logic exec;
	assign exec = i_instr.valid & q.exec_en & ~q.skip_pend;

	// Synchronised pin levels; only the second stage feeds logic.
	logic pin_zero;
	logic pin_one;
	assign pin_zero = q.pin_s2[0];
	assign pin_one  = q.pin_s2[1];

	// Skip conditions of the four test instructions.
	logic sel_zero;     // Request-zero test turned into a null.
	logic sel_one;      // Request-one test turned into a null.
	logic pin0_hit;     // Pin zero at the tested level.
	logic pin1_hit;     // Pin one at the tested level.
	assign sel_zero = q.regs.irq_mask_reg_first[`SKIP_SEL_ZERO_BIT];
	assign sel_one  = q.regs.irq_mask_reg_first[`SKIP_SEL_ONE_BIT];
	assign pin0_hit = (pin_zero ==
		q.regs.irq_edge_reg_first[`LEVEL_POL_BIT]);
	assign pin1_hit = (pin_one ==
		q.regs.irq_edge_reg_second[`LEVEL_POL_BIT]);

	// Next-state logic for the whole block.
	always_comb begin
		logic              skip_now;
		logic              clr_zero;
		logic              clr_one;
		logic [`EVT_WIDTH-1:0] evt_set;
		skip_now = 1'b0;
		clr_zero = 1'b0;
		clr_one  = 1'b0;
		evt_set  = '0;
		d = q;
		// Pulses of the answer last a single cycle.
		d.rsp.acc_load   = 1'b0;
		d.rsp.skip       = 1'b0;
		d.rsp.suppressed = 1'b0;
		// Pins cross into the clock domain through two stages.
		d.pin_s1 = {i_ext_irq_pin_one, i_ext_irq_pin_zero};
		d.pin_s2 = q.pin_s1;
		// A skip drops exactly the next valid instruction.
		if (i_instr.valid && q.skip_pend) begin
			d.skip_pend      = 1'b0;
			d.rsp.suppressed = 1'b1;
		end
		if (exec) begin
			case (i_instr.op)
				OP_NULL_INSTR: begin
					// Nothing changes.
				end
				OP_IRQ_OFF_INSTR: begin
					d.gate = 1'b0;
				end
				OP_IRQ_ON_INSTR: begin
					d.gate = 1'b1;
				end
				OP_SKIP_ON_EXT_REQ_ZERO: begin
					// With the select high the test is a null.
					if (!sel_zero && q.req_zero) begin
						skip_now = 1'b1;
						clr_zero = 1'b1;
					end
				end
				OP_SKIP_ON_EXT_REQ_ONE: begin
					// With the select high the test is a null.
					if (!sel_one && q.req_one) begin
						skip_now = 1'b1;
						clr_one  = 1'b1;
					end
				end
				OP_SKIP_ON_PIN_LEVEL_ZERO: begin
					skip_now = pin0_hit;
				end
				OP_SKIP_ON_PIN_LEVEL_ONE: begin
					skip_now = pin1_hit;
				end
				OP_RD_MASK_FIRST: begin
					d.rsp.acc_load = 1'b1;
					d.rsp.acc_data = q.regs.irq_mask_reg_first;
				end
				OP_WR_MASK_FIRST: begin
					d.regs.irq_mask_reg_first = i_instr.acc;
				end
				OP_RD_MASK_SECOND: begin
					d.rsp.acc_load = 1'b1;
					d.rsp.acc_data = q.regs.irq_mask_reg_second;
				end
				OP_WR_MASK_SECOND: begin
					d.regs.irq_mask_reg_second = i_instr.acc;
				end
				OP_RD_EDGE_FIRST: begin
					d.rsp.acc_load = 1'b1;
					d.rsp.acc_data = q.regs.irq_edge_reg_first;
				end
				OP_WR_EDGE_FIRST: begin
					d.regs.irq_edge_reg_first = i_instr.acc;
				end
				OP_RD_EDGE_SECOND: begin
					d.rsp.acc_load = 1'b1;
					d.rsp.acc_data = q.regs.irq_edge_reg_second;
				end
				OP_WR_EDGE_SECOND: begin
					d.regs.irq_edge_reg_second = i_instr.acc;
				end
				OP_WR_TIMER_AUX: begin
					// Only bit zero of the accumulator is kept.
					d.regs.timer_ctrl_reg_aux = i_instr.acc[0];
				end
				OP_RD_TIMER: begin
					// An index past the fifth register reads zero.
					d.rsp.acc_load = 1'b1;
					d.rsp.acc_data = tmr_read(q.regs, i_instr.tmr_idx);
				end
				OP_WR_TIMER: begin
					// An index past the fifth register is ignored.
					case (i_instr.tmr_idx)
						3'h0: d.regs.timer_ctrl_reg_one   = i_instr.acc;
						3'h1: d.regs.timer_ctrl_reg_two   = i_instr.acc;
						3'h2: d.regs.timer_ctrl_reg_three = i_instr.acc;
						3'h3: d.regs.timer_ctrl_reg_four  = i_instr.acc;
						3'h4: d.regs.timer_ctrl_reg_five  = i_instr.acc;
						default: begin
						end
					endcase
				end
				default: begin
					// Unknown codes act as a null instruction.
				end
			endcase
		end
		if (skip_now) begin
			d.skip_pend = 1'b1;
			d.rsp.skip  = 1'b1;
		end
		// A new request wins over the clear done by a skip test.
		d.req_zero = (q.req_zero & ~clr_zero) | i_ext_req_set[0];
		d.req_one  = (q.req_one & ~clr_one) | i_ext_req_set[1];
		// Events; a set in the clearing cycle is kept.
		evt_set[`EVT_REQ_ZERO] = i_ext_req_set[0];
		evt_set[`EVT_REQ_ONE]  = i_ext_req_set[1];
		evt_set[`EVT_SKIP]     = skip_now;
		if (apb_wr && i_paddr == `OFS_EVT_STATUS) begin
			d.evt_status = q.evt_status & ~i_pwdata[`EVT_WIDTH-1:0];
		end
		d.evt_status = d.evt_status | evt_set;
		// Other software writes.
		if (apb_wr && i_paddr == `OFS_EVT_MASK) begin
			d.evt_mask = i_pwdata[`EVT_WIDTH-1:0];
		end
		if (apb_wr && i_paddr == `OFS_EXEC_CTRL) begin
			d.exec_en = i_pwdata[0];
		end
		// Read data is captured in the setup cycle and shown in access.
		if (i_psel && !i_penable && !i_pwrite) begin
			case (i_paddr)
				`OFS_EVT_STATUS: d.prdata = {29'h0, q.evt_status};
				`OFS_EVT_MASK:   d.prdata = {29'h0, q.evt_mask};
				`OFS_CORE_STATE: d.prdata = {26'h0, pin_one, pin_zero,
					q.skip_pend, q.req_one, q.req_zero, q.gate};
				`OFS_EXEC_CTRL:  d.prdata = {31'h0, q.exec_en};
				default:         d.prdata = 32'h0;
			endcase
		end
	end

	// State register; all fields reset to constants.
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q            <= '0;
			q.regs.irq_mask_reg_first  <= `RST_NIBBLE;
			q.exec_en    <= `RST_EXEC_CTRL;
		end else begin
			q <= d;
		end
	end

	// Outputs. The carry flag has no port here, so it cannot change.
	assign o_rsp                  = q.rsp;
	assign o_ctrl_regs            = q.regs;
	assign o_irq_global_gate_flag = q.gate;
	assign o_ext_req_flag         = {q.req_one, q.req_zero};
	assign o_irq                  = |(q.evt_status & q.evt_mask);
	assign o_pready               = 1'b1;
	assign o_pslverr              = apb_acc & ~addr_ok;
	assign o_prdata               = apb_rd ? q.prdata : 32'h0;

	// Interrupt-off leaves the gate clear.
	chk_gate_off_clears: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_IRQ_OFF_INSTR
		|=> !o_irq_global_gate_flag)
		else $error("gate not cleared by interrupt-off");

	// Interrupt-on leaves the gate set.
	chk_gate_on_sets: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_IRQ_ON_INSTR
		|=> o_irq_global_gate_flag)
		else $error("gate not set by interrupt-on");

	// Request-zero test with a set flag and select low skips and clears.
	// A set pulse in the same cycle keeps the flag, so it is excluded.
	chk_req0_skip_clr: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_SKIP_ON_EXT_REQ_ZERO &&
		!sel_zero && q.req_zero && !i_ext_req_set[0]
		|=> o_rsp.skip && !o_ext_req_flag[0])
		else $error("request-zero skip or clear missing");

	// Request-zero test with select high neither skips nor clears; only
	// a set pulse in the same cycle may still raise the flag.
	chk_req0_null: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_SKIP_ON_EXT_REQ_ZERO && sel_zero
		|=> !o_rsp.skip && o_ext_req_flag[0] ==
		($past(q.req_zero) | $past(i_ext_req_set[0])))
		else $error("request-zero test not a null");

	// Request-one test with a set flag and select low skips and clears.
	chk_req1_skip_clr: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_SKIP_ON_EXT_REQ_ONE &&
		!sel_one && q.req_one && !i_ext_req_set[1]
		|=> o_rsp.skip && !o_ext_req_flag[1])
		else $error("request-one skip or clear missing");

	// Request-one test with select high, or with a clear flag, never
	// skips and never clears the flag.
	chk_req1_null: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_SKIP_ON_EXT_REQ_ONE &&
		(sel_one || !q.req_one)
		|=> !o_rsp.skip && o_ext_req_flag[1] ==
		($past(q.req_one) | $past(i_ext_req_set[1])))
		else $error("request-one test skipped wrongly");

	// Pin-zero test skips exactly when the pin matches the polarity.
	// The test reads the synchronised pin, two edges behind the pad.
	chk_pin0_level: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_SKIP_ON_PIN_LEVEL_ZERO
		|=> o_rsp.skip == ($past(pin_zero) ==
		$past(o_ctrl_regs.irq_edge_reg_first[2])))
		else $error("pin-zero level skip wrong");

	// Pin-one test skips exactly when the pin matches the polarity.
	chk_pin1_level: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_SKIP_ON_PIN_LEVEL_ONE
		|=> o_rsp.skip == ($past(pin_one) ==
		$past(o_ctrl_regs.irq_edge_reg_second[2])))
		else $error("pin-one level skip wrong");

	// A write of the first mask leaves the written value in the register.
	chk_mask_round: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_WR_MASK_FIRST
		|=> o_ctrl_regs.irq_mask_reg_first == $past(i_instr.acc))
		else $error("first mask write lost");

	// The auxiliary timer register keeps bit zero of the accumulator.
	chk_aux_load: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_WR_TIMER_AUX
		|=> o_ctrl_regs.timer_ctrl_reg_aux == $past(i_instr.acc[0]))
		else $error("auxiliary timer load lost");

	// A read of the first timer register hands its value to the accumulator.
	chk_tmr_read: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		exec && i_instr.op == OP_RD_TIMER && i_instr.tmr_idx == 3'h0
		|=> o_rsp.acc_load &&
		o_rsp.acc_data == $past(o_ctrl_regs.timer_ctrl_reg_one))
		else $error("timer read data wrong");

	// The instruction met while a skip is pending is dropped unexecuted,
	// and the mark is gone, so the one after it runs normally.
	chk_skip_one: assert property (
		@(posedge i_ref_clk) disable iff (!rst_n)
		q.skip_pend && i_instr.valid
		|=> o_rsp.suppressed && !o_rsp.acc_load && !o_rsp.skip
		##1 !o_rsp.suppressed)
		else $error("skip did not drop exactly one instruction");

endmodule

// ==== rtl/irq_timer_defines.svh ====
// Offsets, field positions, reset values and widths for the executor.
`ifndef IRQ_TIMER_DEFINES_SVH
`define IRQ_TIMER_DEFINES_SVH

// Register byte offsets on the APB bus.
`define OFS_EVT_STATUS   12'h000
`define OFS_EVT_MASK     12'h004
`define OFS_CORE_STATE   12'h008
`define OFS_EXEC_CTRL    12'h00c

// Event bit positions in the status and mask registers.
`define EVT_REQ_ZERO     0
`define EVT_REQ_ONE      1
`define EVT_SKIP         2
`define EVT_WIDTH        3

// Field positions inside the control registers.
`define SKIP_SEL_ZERO_BIT  0
`define SKIP_SEL_ONE_BIT   1
`define LEVEL_POL_BIT      2

// Reset values of the held registers, and the timer register count.
`define RST_NIBBLE       4'h0
`define RST_EXEC_CTRL    1'h1
`define TMR_COUNT        5

`endif

// ==== rtl/irq_timer_pkg.sv ====
// Types shared by the interrupt and timer control instruction executor.
package irq_timer_pkg;

	// Instructions this block executes; the core decodes opcodes into these.
	typedef enum logic [4:0] {
		OP_NULL_INSTR,
		OP_IRQ_OFF_INSTR,
		OP_IRQ_ON_INSTR,
		OP_SKIP_ON_EXT_REQ_ZERO,
		OP_SKIP_ON_EXT_REQ_ONE,
		OP_SKIP_ON_PIN_LEVEL_ZERO,
		OP_SKIP_ON_PIN_LEVEL_ONE,
		OP_RD_MASK_FIRST,
		OP_WR_MASK_FIRST,
		OP_RD_MASK_SECOND,
		OP_WR_MASK_SECOND,
		OP_RD_EDGE_FIRST,
		OP_WR_EDGE_FIRST,
		OP_RD_EDGE_SECOND,
		OP_WR_EDGE_SECOND,
		OP_WR_TIMER_AUX,
		OP_RD_TIMER,
		OP_WR_TIMER
	} instr_op_t;

	// One instruction as handed over by the core.
	typedef struct packed {
		logic        valid;
		instr_op_t   op;
		logic [2:0]  tmr_idx;
		logic [3:0]  acc;
	} instr_req_t;

	// The held control registers, driven out to the interrupt and timer logic.
	typedef struct packed {
		logic [3:0]  irq_mask_reg_first;
		logic [3:0]  irq_mask_reg_second;
		logic [3:0]  irq_edge_reg_first;
		logic [3:0]  irq_edge_reg_second;
		logic        timer_ctrl_reg_aux;
		logic [3:0]  timer_ctrl_reg_one;
		logic [3:0]  timer_ctrl_reg_two;
		logic [3:0]  timer_ctrl_reg_three;
		logic [3:0]  timer_ctrl_reg_four;
		logic [3:0]  timer_ctrl_reg_five;
	} ctrl_regs_t;

	// Answer to the core for one instruction.
	typedef struct packed {
		logic        acc_load;
		logic [3:0]  acc_data;
		logic        skip;
		logic        suppressed;
	} instr_rsp_t;

endpackage

// ==== tb/irq_timer_ctrl_instr_exec_tb.sv ====
// Self-checking bench for the interrupt and timer instruction executor.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	error_cnt++; $display("Error %s exp %0h got %0h", nm, e, g); end end

module irq_timer_ctrl_instr_exec_tb;
	import irq_timer_pkg::*;
	logic        i_ref_clk;     // Core clock.
	logic        i_rst_b;       // Reset, active low.
	instr_req_t  i_instr;       // Instruction handed to the executor.
	logic [1:0]  i_ext_req_set; // Request flag set pulses.
	logic [1:0]  pin_lvl;       // Levels asked of the pin model.
	logic        pin0, pin1;    // Pin wires.
	logic        i_psel, i_penable, i_pwrite;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic        o_pready, o_pslverr, o_irq, gate, er;
	instr_rsp_t  o_rsp, rsp;
	ctrl_regs_t  regs;
	logic [1:0]  flags;
	int          error_cnt, checks_done, seed, i, n, p, l;
	int          mdl[0:4];      // Behavioural copy of written values.
	instr_op_t   wr_op[0:3], rd_op[0:3];

	irq_timer_ctrl_instr_exec u_dut (.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b), .i_instr(i_instr),
		.i_ext_req_set(i_ext_req_set), .i_ext_irq_pin_zero(pin0),
		.i_ext_irq_pin_one(pin1), .i_psel(i_psel), .i_penable(i_penable),
		.i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.o_rsp(o_rsp), .o_ctrl_regs(regs), .o_irq_global_gate_flag(gate),
		.o_ext_req_flag(flags), .o_irq(o_irq));

	pin_level_model u_pins (.i_ref_clk(i_ref_clk), .i_level(pin_lvl),
		.o_pin_zero(pin0), .o_pin_one(pin1));

	// Free-running 250 MHz clock.
	initial begin
		i_ref_clk = 1'b0;
		forever #2 i_ref_clk = ~i_ref_clk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic finish_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Presents one instruction for one cycle and captures the answer.
	task automatic exec(input instr_op_t op, input logic [2:0] ix,
		input logic [3:0] a);
		@(posedge i_ref_clk);
		i_instr <= '{1'b1, op, ix, a};
		@(posedge i_ref_clk);
		i_instr.valid <= 1'b0;
		#1 rsp = o_rsp;
	endtask

	// One APB transfer; a wait for pready is bounded so a hang ends the run.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge i_ref_clk);
		i_psel   <= 1'b1;
		i_pwrite <= w;
		i_paddr  <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge i_ref_clk);
			if (o_pready === 1'b1) break;
		end
		if (k == 16) begin
			error_cnt++;
			finish_test();
		end
		rd = o_prdata;
		er = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	// One-cycle pulse on a request flag set input.
	task automatic pulse(input int k);
		@(posedge i_ref_clk);
		i_ext_req_set <= 2'(1 << k);
		@(posedge i_ref_clk);
		i_ext_req_set <= 2'b00;
		#1;
	endtask

	initial begin
		seed = 32'h39638278;
		i_rst_b = 1'b0;
		i_instr = '0;
		i_ext_req_set = 2'b00;
		pin_lvl = 2'b11;
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
		wr_op = '{OP_WR_MASK_FIRST, OP_WR_MASK_SECOND, OP_WR_EDGE_FIRST,
			OP_WR_EDGE_SECOND};
		rd_op = '{OP_RD_MASK_FIRST, OP_RD_MASK_SECOND, OP_RD_EDGE_FIRST,
			OP_RD_EDGE_SECOND};
		repeat (12) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		apb(1'b0, 12'h00c, 32'h0);
		`CHK("exec_en", 32'h1, rd)
		// Gate flag on, then off; a disabled executor ignores the request.
		exec(OP_IRQ_ON_INSTR, 3'h0, 4'h0);
		`CHK("gate_on", 1'b1, gate)
		exec(OP_IRQ_OFF_INSTR, 3'h0, 4'h0);
		`CHK("gate_off", 1'b0, gate)
		apb(1'b1, 12'h00c, 32'h0);
		exec(OP_IRQ_ON_INSTR, 3'h0, 4'h0);
		`CHK("gate_held", 1'b0, gate)
		apb(1'b1, 12'h00c, 32'h1);
		$display("test gate done");
		// Mask and edge registers: write random values, read them back.
		for (i = 0; i < 4; i++) begin
			mdl[i] = $random(seed) & 15;
			exec(wr_op[i], 3'h0, 4'(mdl[i]));
			`CHK("wr_noload", 1'b0, rsp.acc_load)
		end
		for (i = 0; i < 4; i++) begin
			exec(rd_op[i], 3'h0, 4'h0);
			`CHK("rd_load", 1'b1, rsp.acc_load)
			`CHK("rd_data", 4'(mdl[i]), rsp.acc_data)
		end
		// Timer registers one to five, plus an index beyond the last.
		for (i = 0; i < 5; i++) begin
			mdl[i] = $random(seed) & 15;
			exec(OP_WR_TIMER, 3'(i), 4'(mdl[i]));
		end
		for (i = 0; i < 6; i++) begin
			exec(OP_RD_TIMER, 3'(i), 4'h0);
			`CHK("tmr", (i < 5) ? 4'(mdl[i]) : 4'h0, rsp.acc_data)
		end
		l = $random(seed) & 15;
		exec(OP_WR_TIMER_AUX, 3'h0, 4'(l));
		`CHK("aux", 1'(l), regs.timer_ctrl_reg_aux)
		$display("test moves done");
		// Request skips, select low then high, for both flags.
		for (n = 0; n < 2; n++) begin
			for (p = 0; p < 2; p++) begin
				exec(OP_WR_MASK_FIRST, 3'h0, 4'(p << n));
				pulse(n);
				exec(n ? OP_SKIP_ON_EXT_REQ_ONE : OP_SKIP_ON_EXT_REQ_ZERO,
					3'h0, 4'h0);
				`CHK("req_skip", 1'(p == 0), rsp.skip)
				`CHK("req_flag", 1'(p), flags[n])
				exec(OP_RD_MASK_FIRST, 3'h0, 4'h0);
				`CHK("sup", 1'(p == 0), rsp.suppressed)
				`CHK("sup_ld", 1'(p), rsp.acc_load)
				exec(OP_RD_MASK_FIRST, 3'h0, 4'h0);
				`CHK("one_only", 1'b1, rsp.acc_load)
			end
			exec(n ? OP_SKIP_ON_EXT_REQ_ONE : OP_SKIP_ON_EXT_REQ_ZERO,
				3'h0, 4'h0);
			`CHK("req_noskip", 1'b0, rsp.skip)
		end
		$display("test request skips done");
		// Pin level skips for every polarity and level on both pins.
		for (n = 0; n < 2; n++) begin
			for (p = 0; p < 2; p++) begin
				for (l = 0; l < 2; l++) begin
					exec(n ? OP_WR_EDGE_SECOND : OP_WR_EDGE_FIRST, 3'h0,
						4'(p << 2));
					@(posedge i_ref_clk);
					pin_lvl[n] <= 1'(l);
					repeat (5) @(posedge i_ref_clk);
					exec(n ? OP_SKIP_ON_PIN_LEVEL_ONE
						: OP_SKIP_ON_PIN_LEVEL_ZERO, 3'h0, 4'h0);
					`CHK("pin_skip", 1'(l == p), rsp.skip)
					if (l == p) begin
						exec(OP_NULL_INSTR, 3'h0, 4'h0);
						`CHK("pin_sup", 1'b1, rsp.suppressed)
					end
				end
			end
		end
		$display("test pin skips done");
		// Events, mask, write-one-to-clear and the unmapped address.
		apb(1'b1, 12'h004, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("status", 32'h7, rd)
		`CHK("irq_on", 1'b1, o_irq)
		apb(1'b1, 12'h000, 32'h7);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("cleared", 32'h0, rd)
		`CHK("irq_off", 1'b0, o_irq)
		apb(1'b1, 12'h004, 32'h0);
		pulse(0);
		#1;
		`CHK("irq_mask", 1'b0, o_irq)
		apb(1'b0, 12'h010, 32'h0);
		`CHK("unmapped", 1'b1, er)
		`CHK("unmap_rd", 32'h0, rd)
		// Core state: gate off, both flags held, no skip, both pins high.
		apb(1'b0, 12'h008, 32'h0);
		`CHK("core_state", 32'h36, rd)
		$display("test bus and interrupt done");
		finish_test();
	end
endmodule

// ==== tb/pin_level_model.sv ====
// Model of the two external interrupt pins seen by the executor.
`timescale 1ns/1ps

module pin_level_model (
	input  wire logic       i_ref_clk,
	input  wire logic [1:0] i_level,
	output logic            o_pin_zero,
	output logic            o_pin_one
);
	// Pins idle high, as if pulled up, until the bench asks otherwise;
	// levels change just after an edge, as a slow pin would. One process
	// owns both outputs so that each has a single driver.
	initial begin
		o_pin_zero = 1'b1;
		o_pin_one  = 1'b1;
		forever begin
			@(posedge i_ref_clk);
			o_pin_zero <= i_level[0];
			o_pin_one  <= i_level[1];
		end
	end
endmodule
